// ### rtl/fpd_defs.svh
// Offsets, field positions, reset values and timing counts of the failure point monitor.
// Behaviour
// - idle while execution off, else time interval
// - timeout raises alarm numbered by control, 00 none
// - timeout writes first OFF condition address
// - highest line, leftmost condition is chosen
// - timeout sets the timeout flag
// - control bit 15 selects ASCII address plus message
// - word 0 flags address present and NC
// - binary code carries area, word and bit
// - timer/counter code bit 09 marks counter
// - binary bit-number bit 03 is stored inverted
// - IR/SR bit 13 marks upper word range
// - message words 1-4 hold space, address, hyphen, contact
// - words 5-8 hold the user message
// - auto tune stores 1.5 times interval, no alarm
// - constant monitoring time is never rewritten
// - error flag on bad time or control word
// - error flag on bad indirect word
`ifndef FPD_DEFS_SVH
`define FPD_DEFS_SVH
`define FPD_NCOND 4
`define FPD_A_CTRL 8'h00
`define FPD_A_TIME 8'h04
`define FPD_A_COND 8'h08
`define FPD_A_STAT 8'h0c
`define FPD_A_ELAP 8'h10
`define FPD_A_ADDR0 8'h20
`define FPD_A_ADDRL 8'h2c
`define FPD_A_RES0 8'h40
`define FPD_A_RESL 8'h60
`define FPD_C_CONST 16
`define FPD_C_TWORD 17
`define FPD_C_TUNE 18
`define FPD_C_INDF 19
`define FPD_CW_MSG 15
`define FPD_S_TO 0
`define FPD_S_AL 2
`define FPD_RST_T 16'h0000
`define FPD_UNIT_MS 100
`define FPD_CLK_MHZ 100
`define FPD_TICK_CYC (`FPD_UNIT_MS * 1000 * `FPD_CLK_MHZ)
`define FPD_T_MAX 14'h270f
`define FPD_CODE_IR 2'b10
`define FPD_CODE_EXT 4'b1001
`define FPD_ASC_SP 8'h20
`define FPD_ASC_HY 8'h2d
`define FPD_ASC_0 8'h30
`define FPD_OKAY 2'b00
`define FPD_SLVERR 2'b10
`endif

// ### rtl/fpd_pkg.sv
// Types shared by the failure point monitor.
package fpd_pkg;
	typedef enum logic [2:0] {FPD_IR = 3'h0, FPD_HR = 3'h1, FPD_LR = 3'h2, FPD_TIM = 3'h3, FPD_CNT = 3'h4} fpd_area_e;
	typedef struct packed {
		fpd_area_e area;
		logic [8:0] num;
		logic [3:0] bitn;
	} fpd_addr_s;
	typedef struct packed {
		logic diag;
		logic exec;
		logic [3:0] nc;
		logic [3:0] val;
	} fpd_cond_s;
	typedef enum logic [1:0] {FPD_IDLE = 2'b00, FPD_TIMING = 2'b01, FPD_DONE = 2'b11, FPD_TUNING = 2'b10} fpd_state_e;
endpackage

// ### rtl/fpd_monitor.sv
// Failure point detection unit with an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "fpd_defs.svh"
module fpd_monitor import fpd_pkg::*; #(
	parameter int unsigned TICK_CYC = `FPD_TICK_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic timeout_flag,
	output logic error_flag,
	output logic user_fault_alarm,
	output logic [7:0] alarm_num
);
	function automatic logic is_bcd(input logic [15:0] v);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (v[4*i +: 4] > 4'h9) ok = 1'b0;
		end
		return ok;
	endfunction

	function automatic logic [15:0] bin2bcd(input logic [13:0] v);
		logic [29:0] s;
		s = {16'h0000, v};
		for (int i = 0; i < 14; i++) begin
			for (int d = 0; d < 4; d++) begin
				if (s[14+4*d +: 4] > 4'h4) s[14+4*d +: 4] = s[14+4*d +: 4] + 4'h3;
			end
			s = s << 1;
		end
		return s[29:14];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	// Bus and software register state.
	logic awv_reg, awv_next, wv_reg, wv_next, awready_reg, awready_next, wready_reg, wready_next;
	logic [7:0] awa_reg, awa_next;
	logic [31:0] wd_reg, wd_next;
	logic [3:0] ws_reg, ws_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [19:0] ctrl_reg, ctrl_next;
	logic [15:0] t_reg, t_next;
	fpd_cond_s cond_reg, cond_next;
	fpd_addr_s addr_reg [`FPD_NCOND], addr_next [`FPD_NCOND];
	logic [15:0] msg_reg [4], msg_next [4];
	logic to_reg, to_next, al_reg, al_next;
	logic [7:0] alnum_reg, alnum_next;
	// Core state.
	fpd_state_e state_reg, state_next;
	logic [31:0] div_reg, div_next;
	logic [15:0] elap_reg, elap_next;
	logic er_reg, er_next, to_evt_reg, to_evt_next, al_evt_reg, al_evt_next, tw_reg, tw_next;
	logic [15:0] tv_reg, tv_next;
	logic [15:0] res_reg [5], res_next [5];

	logic [15:0] cw, t_bin;
	logic err, found, tick, sel_nc;
	logic [3:0] off_vec, bitx;
	logic [1:0] sel;
	fpd_addr_s sa;
	logic [15:0] code, dn, db;
	logic [7:0] asc [5];
	logic [17:0] x15;
	logic [13:0] tune_bin;

	assign cw = ctrl_reg[15:0];
	assign t_bin = 16'(t_reg[15:12]) * 16'd1000 + 16'(t_reg[11:8]) * 16'd100 + 16'(t_reg[7:4]) * 16'd10
		+ 16'(t_reg[3:0]);
	assign err = !is_bcd(t_reg) || !ctrl_reg[`FPD_C_CONST] || !is_bcd({8'h00, cw[7:0]})
		|| ctrl_reg[`FPD_C_INDF];
	assign off_vec = ~(cond_reg.val ^ cond_reg.nc);
	assign found = |off_vec;
	assign tick = div_reg == TICK_CYC - 1;
	assign x15 = (18'(elap_reg) * 18'd3) >> 1;
	assign tune_bin = (x15 > 18'(`FPD_T_MAX)) ? `FPD_T_MAX : x15[13:0];

	// Lowest index is the highest line, nearest the left bus bar.
	always_comb begin
		sel = 2'd0;
		for (int i = `FPD_NCOND - 1; i >= 0; i--) begin
			if (off_vec[i]) sel = 2'(i);
		end
	end

	assign sa = addr_reg[sel];
	assign sel_nc = cond_reg.nc[sel];
	assign bitx = {~sa.bitn[3], sa.bitn[2:0]};
	assign dn = bin2bcd(14'(sa.num));
	assign db = bin2bcd(14'(sa.bitn));

	always_comb begin
		case (sa.area)
			FPD_IR: code = {`FPD_CODE_IR, sa.num[8], 1'b0, sa.num[7:0], bitx};
			FPD_HR: code = {`FPD_CODE_EXT, 1'b1, sa.num[6:0], bitx};
			FPD_LR: code = {`FPD_CODE_EXT, 2'b00, sa.num[5:0], bitx};
			FPD_TIM: code = {`FPD_CODE_EXT, 2'b01, 1'b0, sa.num};
			FPD_CNT: code = {`FPD_CODE_EXT, 2'b01, 1'b1, sa.num};
			default: code = 16'h0000;
		endcase
		asc[0] = `FPD_ASC_0 | {4'h0, dn[11:8]};
		asc[1] = `FPD_ASC_0 | {4'h0, dn[7:4]};
		asc[2] = `FPD_ASC_0 | {4'h0, dn[3:0]};
		asc[3] = `FPD_ASC_0 | {4'h0, db[7:4]};
		asc[4] = `FPD_ASC_0 | {4'h0, db[3:0]};
	end

	always_comb begin
		state_next = state_reg;
		div_next = div_reg;
		elap_next = elap_reg;
		er_next = er_reg;
		to_evt_next = 1'b0;
		al_evt_next = 1'b0;
		tw_next = 1'b0;
		tv_next = tv_reg;
		res_next = res_reg;
		if ((state_reg == FPD_TIMING || state_reg == FPD_TUNING) && !cond_reg.diag) begin
			div_next = tick ? 32'h0000_0000 : div_reg + 32'h0000_0001;
			if (tick && elap_reg != 16'hffff) elap_next = elap_reg + 16'h0001;
		end
		case (state_reg)
			FPD_IDLE: begin
				if (cond_reg.exec) begin
					er_next = err;
					if (!err) begin
						state_next = FPD_TIMING;
						div_next = 32'h0000_0000;
						elap_next = 16'h0000;
					end
				end
			end
			FPD_TIMING: begin
				if (!cond_reg.exec) begin
					state_next = FPD_IDLE;
				end else if (cond_reg.diag) begin
					state_next = FPD_DONE;
				end else if (elap_reg > t_bin) begin
					to_evt_next = 1'b1;
					al_evt_next = !ctrl_reg[`FPD_C_TUNE] && cw[7:0] != 8'h00;
					state_next = (ctrl_reg[`FPD_C_TUNE] && ctrl_reg[`FPD_C_TWORD]) ? FPD_TUNING : FPD_DONE;
					res_next[0] = {found, found & sel_nc, 14'h0000};
					if (!found) begin
						for (int i = 1; i < 5; i++) res_next[i] = 16'h0000;
					end else if (cw[`FPD_CW_MSG]) begin
						res_next[1] = {`FPD_ASC_SP, asc[0]};
						res_next[2] = {asc[1], asc[2]};
						res_next[3] = {asc[3], asc[4]};
						res_next[4] = {`FPD_ASC_HY, `FPD_ASC_0 | {7'h00, sel_nc}};
					end else begin
						res_next[1] = code;
					end
				end
			end
			FPD_TUNING: begin
				if (!cond_reg.exec) begin
					state_next = FPD_IDLE;
				end else if (cond_reg.diag) begin
					tw_next = 1'b1;
					tv_next = bin2bcd(tune_bin);
					state_next = FPD_DONE;
				end
			end
			FPD_DONE: begin
				if (!cond_reg.exec) state_next = FPD_IDLE;
			end
			default: state_next = FPD_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= FPD_IDLE;
			div_reg <= 32'h0000_0000;
			elap_reg <= 16'h0000;
			er_reg <= 1'b0;
			to_evt_reg <= 1'b0;
			al_evt_reg <= 1'b0;
			tw_reg <= 1'b0;
			tv_reg <= 16'h0000;
			for (int i = 0; i < 5; i++) res_reg[i] <= 16'h0000;
		end else begin
			state_reg <= state_next;
			div_reg <= div_next;
			elap_reg <= elap_next;
			er_reg <= er_next;
			to_evt_reg <= to_evt_next;
			al_evt_reg <= al_evt_next;
			tw_reg <= tw_next;
			tv_reg <= tv_next;
			res_reg <= res_next;
		end
	end

	logic do_wr;
	logic [31:0] wm;
	logic [7:0] ra;
	logic [3:0] ri;
	assign do_wr = awv_reg && wv_reg && !bvalid_reg;
	assign ra = {araddr[7:2], 2'b00};
	assign ri = 4'((ra - `FPD_A_RES0) >> 2);

	always_comb begin
		awv_next = awv_reg || (awvalid && awready_reg);
		wv_next = wv_reg || (wvalid && wready_reg);
		awa_next = (awvalid && awready_reg) ? {awaddr[7:2], 2'b00} : awa_reg;
		wd_next = (wvalid && wready_reg) ? wdata : wd_reg;
		ws_next = (wvalid && wready_reg) ? wstrb : ws_reg;
		bvalid_next = bvalid_reg && !bready;
		bresp_next = bresp_reg;
		ctrl_next = ctrl_reg;
		t_next = t_reg;
		cond_next = cond_reg;
		addr_next = addr_reg;
		msg_next = msg_reg;
		to_next = to_reg;
		al_next = al_reg;
		alnum_next = alnum_reg;
		wm = 32'h0000_0000;
		if (do_wr) begin
			awv_next = 1'b0;
			wv_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = `FPD_OKAY;
			if (awa_reg == `FPD_A_CTRL) begin
				ctrl_next = 20'(merge({12'h000, ctrl_reg}, wd_reg, ws_reg));
			end else if (awa_reg == `FPD_A_TIME) begin
				t_next = 16'(merge({16'h0000, t_reg}, wd_reg, ws_reg));
			end else if (awa_reg == `FPD_A_COND) begin
				cond_next = fpd_cond_s'(10'(merge({22'h000000, cond_reg}, wd_reg, ws_reg)));
			end else if (awa_reg == `FPD_A_STAT) begin
				wm = ws_reg[0] ? wd_reg : 32'h0000_0000;
				if (wm[`FPD_S_TO]) to_next = 1'b0;
				if (wm[`FPD_S_AL]) al_next = 1'b0;
			end else if (awa_reg >= `FPD_A_ADDR0 && awa_reg <= `FPD_A_ADDRL) begin
				addr_next[awa_reg[3:2]] = fpd_addr_s'(16'(merge({16'h0000, addr_reg[awa_reg[3:2]]}, wd_reg, ws_reg)));
			end else if (awa_reg >= `FPD_A_RES0 + 8'h14 && awa_reg <= `FPD_A_RESL) begin
				wm = merge({16'h0000, msg_reg[2'(awa_reg[3:2] - 2'd1)]}, wd_reg, ws_reg);
				msg_next[2'(awa_reg[3:2] - 2'd1)] = wm[15:0];
			end else if (awa_reg != `FPD_A_ELAP && !(awa_reg >= `FPD_A_RES0 && awa_reg <= `FPD_A_RESL)) begin
				bresp_next = `FPD_SLVERR;
			end
		end
		if (tw_reg) t_next = tv_reg;
		if (to_evt_reg) to_next = 1'b1;
		if (al_evt_reg) begin
			al_next = 1'b1;
			alnum_next = cw[7:0];
		end
		awready_next = !awv_next && !bvalid_next;
		wready_next = !wv_next && !bvalid_next;
		rvalid_next = rvalid_reg && !rready;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (arvalid && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next = `FPD_OKAY;
			rdata_next = 32'h0000_0000;
			if (ra == `FPD_A_CTRL) rdata_next = {12'h000, ctrl_reg};
			else if (ra == `FPD_A_TIME) rdata_next = {16'h0000, t_reg};
			else if (ra == `FPD_A_COND) rdata_next = {22'h000000, cond_reg};
			else if (ra == `FPD_A_STAT) rdata_next = {14'h0000, state_reg, alnum_reg, 5'h00, al_reg, er_reg, to_reg};
			else if (ra == `FPD_A_ELAP) rdata_next = {16'h0000, elap_reg};
			else if (ra >= `FPD_A_ADDR0 && ra <= `FPD_A_ADDRL) rdata_next = {16'h0000, addr_reg[ra[3:2]]};
			else if (ra >= `FPD_A_RES0 && ra <= `FPD_A_RESL)
				rdata_next = {16'h0000, (ri < 4'd5) ? res_reg[3'(ri)] : msg_reg[2'(ri - 4'd5)]};
			else rresp_next = `FPD_SLVERR;
		end
		arready_next = !rvalid_next;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awv_reg <= 1'b0;
			wv_reg <= 1'b0;
			awa_reg <= 8'h00;
			wd_reg <= 32'h0000_0000;
			ws_reg <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'b00;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= 2'b00;
			ctrl_reg <= 20'h00000;
			t_reg <= `FPD_RST_T;
			cond_reg <= '0;
			for (int i = 0; i < 4; i++) begin
				addr_reg[i] <= '0;
				msg_reg[i] <= 16'h0000;
			end
			to_reg <= 1'b0;
			al_reg <= 1'b0;
			alnum_reg <= 8'h00;
		end else begin
			awv_reg <= awv_next;
			wv_reg <= wv_next;
			awa_reg <= awa_next;
			wd_reg <= wd_next;
			ws_reg <= ws_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			ctrl_reg <= ctrl_next;
			t_reg <= t_next;
			cond_reg <= cond_next;
			addr_reg <= addr_next;
			msg_reg <= msg_next;
			to_reg <= to_next;
			al_reg <= al_next;
			alnum_reg <= alnum_next;
		end
	end

	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign timeout_flag = to_reg;
	assign error_flag = er_reg;
	assign user_fault_alarm = al_reg;
	assign alarm_num = alnum_reg;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_idle_exec_off: assert property (!cond_reg.exec |=> state_reg == FPD_IDLE)
		else $error("Monitor left idle with execution off.");
	a_alarm_number: assert property (al_evt_reg |=> al_reg && alarm_num == $past(cw[7:0]) && alarm_num != 8'h00)
		else $error("Alarm number wrong or alarm 00 raised.");
	a_timeout_flag_set: assert property (to_evt_next |-> ##2 timeout_flag)
		else $error("Timeout did not set the flag.");
	a_first_off_pick: assert property (to_evt_next && found |=> res_reg[0][15] && res_reg[0][14] == $past(sel_nc)
		&& $past(off_vec & ((4'h1 << sel) - 4'h1)) == 4'h0)
		else $error("Wrong OFF condition selected.");
	a_bit3_inverted: assert property (to_evt_next && found && !cw[`FPD_CW_MSG] && sa.area == FPD_IR
		|=> res_reg[1][3] == !$past(sa.bitn[3]))
		else $error("Bit 03 of address code not inverted.");
	a_msg_hyphen: assert property (to_evt_next && found && cw[`FPD_CW_MSG]
		|=> res_reg[4][15:8] == `FPD_ASC_HY && res_reg[1][15:8] == `FPD_ASC_SP)
		else $error("Message address layout wrong.");
	a_tune_no_alarm: assert property (ctrl_reg[`FPD_C_TUNE] |-> !al_evt_next)
		else $error("Alarm raised while tuning.");
	a_const_t_kept: assert property (tw_reg |-> ctrl_reg[`FPD_C_TWORD] ##1 t_reg == $past(tv_reg))
		else $error("Constant monitoring time rewritten.");
	a_error_flag: assert property (state_reg == FPD_IDLE && cond_reg.exec && !is_bcd(t_reg) |=> error_flag)
		else $error("Non-BCD time did not set the error flag.");
	a_timer_restart: assert property (state_reg == FPD_IDLE ##1 state_reg == FPD_TIMING |-> elap_reg == 16'h0000)
		else $error("Timer did not restart from zero.");
endmodule

// ### tb/fpd_periph_model.sv
// Peripheral device model: an AXI4-Lite master that loads and reads the monitor.
`timescale 1ns/1ps
module fpd_periph_model (
	input wire logic aclk,
	output logic awvalid,
	input wire logic awready,
	output logic [7:0] awaddr,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	input wire logic [1:0] bresp,
	output logic arvalid,
	input wire logic arready,
	output logic [7:0] araddr,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	initial begin
		awvalid = 1'b0;
		awaddr = 8'h00;
		wvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'hf;
		bready = 1'b0;
		arvalid = 1'b0;
		araddr = 8'h00;
		rready = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp, output logic ok);
		int n;
		ok = 1'b0;
		n = 0;
		resp = 2'b11;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		while (!ok && n < 100) begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
			if (bvalid) begin
				resp = bresp;
				bready <= 1'b0;
				ok = 1'b1;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp, output logic ok);
		int n;
		ok = 1'b0;
		n = 0;
		d = 32'h0;
		resp = 2'b11;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		while (!ok && n < 100) begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
			if (rvalid) begin
				d = rdata;
				resp = rresp;
				rready <= 1'b0;
				ok = 1'b1;
			end
		end
	endtask
endmodule

// ### tb/fpd_monitor_tb_top.sv
// Self-checking bench of the failure point monitor.
`timescale 1ns/1ps
`include "fpd_defs.svh"
module fpd_monitor_tb_top;
	localparam int TICK = 4;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr, alarm_num;
	logic [31:0] wdata, rdata, rd_d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	logic timeout_flag, error_flag, user_fault_alarm, ok;
	int n_errors = 0;
	int checked = 0;
	fpd_monitor #(.TICK_CYC(TICK)) fpd_monitor_inst (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
		.rdata, .rresp, .timeout_flag, .error_flag, .user_fault_alarm, .alarm_num);
	fpd_periph_model fpd_periph_model_inst (.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
		.wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic hang();
		n_errors++;
		complete_run();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		fpd_periph_model_inst.wr(a, d, rsp, ok);
		if (!ok) hang();
	endtask
	task automatic rd(input logic [7:0] a);
		fpd_periph_model_inst.rd(a, rd_d, rsp, ok);
		if (!ok) hang();
	endtask
	task automatic arm(input logic [31:0] cond);
		wr(`FPD_A_COND, cond);
		wr(`FPD_A_COND, cond | 32'h100);
	endtask
	task automatic wait_to();
		int n;
		n = 0;
		while (timeout_flag !== 1'b1 && n < 100) begin
			@(posedge aclk);
			n++;
		end
		if (timeout_flag !== 1'b1) hang();
		repeat (3) @(posedge aclk);
	endtask
	task automatic setup(input logic [31:0] ctrl, input logic [31:0] t);
		wr(`FPD_A_COND, 32'h0);
		wr(`FPD_A_STAT, 32'h5);
		wr(`FPD_A_CTRL, ctrl);
		wr(`FPD_A_TIME, t);
	endtask
	task automatic t_reset();
		rd(`FPD_A_STAT);
		check("stat", rd_d, 32'h0);
		rd(`FPD_A_TIME);
		check("time", rd_d, 32'(`FPD_RST_T));
		rd(8'h14);
		check("unmapped_rd", {rd_d[29:0], rsp}, 32'(`FPD_SLVERR));
		wr(8'h14, 32'h1);
		check("unmapped_wr", 32'(rsp), 32'(`FPD_SLVERR));
		$display("done reset");
	endtask
	task automatic bin_case(input logic [7:0] slot, input logic [31:0] adr, input logic [31:0] cond,
		input logic [31:0] exp_d, input logic [31:0] mask, input logic [31:0] exp_a);
		setup(32'h10010, 32'h2);
		wr(slot, adr);
		arm(cond);
		check("early", 32'(timeout_flag), 32'h0);
		check("err_ok", 32'(error_flag), 32'h0);
		wait_to();
		check("alarm", 32'(user_fault_alarm), 32'h1);
		check("alarm_num", 32'(alarm_num), 32'h10);
		rd(`FPD_A_STAT);
		check("stat_to", 32'(rd_d[0]), 32'h1);
		rd(`FPD_A_RES0);
		check("d0", rd_d, exp_d);
		rd(`FPD_A_RES0 + 8'h4);
		check("d1", rd_d & mask, exp_a);
		$display("done binary");
	endtask
	task automatic t_msg();
		logic [15:0] exp [9] = '{16'hc000, 16'h2031, 16'h3030, 16'h3032, 16'h2d31, 16'h4142, 16'h430d, 0, 0};
		setup(32'h18000, 32'h2);
		wr(`FPD_A_RES0 + 8'h14, 32'h4142);
		wr(`FPD_A_RES0 + 8'h18, 32'h430d);
		arm(32'hcf);
		wait_to();
		check("alarm_00", 32'(user_fault_alarm), 32'h0);
		for (int k = 0; k < 9; k++) begin
			rd(`FPD_A_RES0 + 8'(4 * k));
			check("msg", rd_d, {16'h0, exp[k]});
		end
		$display("done message");
	endtask
	task automatic t_idle();
		setup(32'h10010, 32'h5);
		wr(`FPD_A_COND, 32'hcf);
		repeat (60) @(posedge aclk);
		check("idle", 32'(timeout_flag), 32'h0);
		arm(32'hcf);
		wr(`FPD_A_COND, 32'h3cf);
		repeat (60) @(posedge aclk);
		check("diag", 32'(timeout_flag), 32'h0);
		wr(`FPD_A_COND, 32'hcf);
		arm(32'hcf);
		repeat (8) @(posedge aclk);
		check("restart", 32'(timeout_flag), 32'h0);
		wait_to();
		$display("done idle");
	endtask
	task automatic err_case(input logic [31:0] ctrl, input logic [31:0] t);
		setup(ctrl, t);
		arm(32'hcf);
		repeat (30) @(posedge aclk);
		check("err", 32'(error_flag), 32'h1);
		check("err_to", 32'(timeout_flag), 32'h0);
	endtask
	task automatic t_tune();
		logic [31:0] e, x;
		setup(32'h70010, 32'h1);
		arm(32'hcf);
		repeat (40) @(posedge aclk);
		wr(`FPD_A_COND, 32'h3cf);
		repeat (4) @(posedge aclk);
		rd(`FPD_A_ELAP);
		e = rd_d;
		check("elap", 32'(e > 32'd8 && e < 32'd20), 32'h1);
		x = e * 3 / 2;
		x = {16'h0, 4'(x / 1000), 4'(x / 100 % 10), 4'(x / 10 % 10), 4'(x % 10)};
		rd(`FPD_A_TIME);
		check("tuned", rd_d, x);
		check("tune_al", 32'(user_fault_alarm), 32'h0);
		setup(32'h50010, 32'h1);
		arm(32'hcf);
		repeat (40) @(posedge aclk);
		wr(`FPD_A_COND, 32'h3cf);
		repeat (4) @(posedge aclk);
		rd(`FPD_A_TIME);
		check("const_t", rd_d, 32'h1);
		check("const_al", 32'(user_fault_alarm), 32'h0);
		$display("done tune");
	endtask
	initial begin
		aresetn = 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		bin_case(`FPD_A_ADDR0 + 8'h8, 32'h0642, 32'hcf, 32'hc000, 32'hffff, 32'h864a);
		bin_case(`FPD_A_ADDR0, 32'h8070, 32'h1f, 32'hc000, 32'hf200, 32'h9200);
		bin_case(`FPD_A_ADDR0 + 8'h4, 32'h6070, 32'h2f, 32'hc000, 32'hf200, 32'h9000);
		bin_case(`FPD_A_ADDRL, 32'h12cf, 32'h07, 32'h8000, 32'hffff, 32'ha2c7);
		t_msg();
		t_idle();
		err_case(32'h10010, 32'h00a0);
		err_case(32'h00010, 32'h0002);
		err_case(32'h1001a, 32'h0002);
		err_case(32'h90010, 32'h0002);
		$display("done errors");
		t_tune();
		complete_run();
	end
endmodule
